// File: design/sac_pkg.sv
// sac_pkg: shared constants, types and state codes of the conversion interface
// assumes a 25 MHz internal conversion clock and a host-driven serial clock
package sac_pkg;

    // ----------------------------------------------------------------
    // widths and depths
    // ----------------------------------------------------------------
    localparam int RES_BITS = 16;
    localparam int IDX_W = $clog2(RES_BITS);
    localparam int FIFO_DEPTH = 32;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int SAMPLE_PERIOD_NS = 1000;
    // least spacing between starts, rounded up
    localparam int SAMPLE_PERIOD_CYC = (SAMPLE_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SPACE_W = $clog2(SAMPLE_PERIOD_CYC + 1);
    localparam int CAL_SETTLE_NS = 1280;
    localparam int CAL_SETTLE_CYC = CAL_SETTLE_NS / CLOCK_PERIOD_NS;
    localparam int CAL_W = $clog2(CAL_SETTLE_CYC + 1);

    // ----------------------------------------------------------------
    // reset values and codes
    // ----------------------------------------------------------------
    localparam logic [RES_BITS-1:0] MIDSCALE = {1'b1, {(RES_BITS-1){1'b0}}};
    localparam logic [RES_BITS-1:0] TRIM_RESET = MIDSCALE;
    localparam logic [RES_BITS-1:0] CODE_MAX = {RES_BITS{1'b1}};

    typedef logic [RES_BITS-1:0] sac_code_t;

    typedef struct packed {
        sac_code_t code;
        logic trimmed;
    } sac_result_s;

    localparam int RESULT_W = $bits(sac_result_s);

    typedef enum logic [4:0] {
        ST_CAL = 5'h01,
        ST_STANDBY = 5'h02,
        ST_CONVERT = 5'h04,
        ST_HOLD = 5'h08,
        ST_PUSH = 5'h10
    } sac_state_e;

endpackage : sac_pkg

// File: design/sac_fifo.sv
// sac_fifo: result buffer with valid/ready on both sides
// assumes one clock for both sides and a synchronous active-low reset
`timescale 1ns/10ps
module sac_fifo
    import sac_pkg::*;
#(
    parameter int WIDTH = RESULT_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W:0] wrPtr_q;
    logic [PTR_W:0] rdPtr_q;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty
    assign empty = (wrPtr_q == rdPtr_q);
    assign full = (wrPtr_q[PTR_W] != rdPtr_q[PTR_W]) && (wrPtr_q[PTR_W-1:0] == rdPtr_q[PTR_W-1:0]);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_q[PTR_W-1:0]];

    always_ff @(posedge clock)
    begin
        if (inValid && !full)
        begin
            mem[wrPtr_q[PTR_W-1:0]] <= inData;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            wrPtr_q <= '0;
        end
        else if (inValid && !full)
        begin
            wrPtr_q <= wrPtr_q + 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            rdPtr_q <= '0;
        end
        else if (outReady && !empty)
        begin
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end

endmodule : sac_fifo

// File: design/sac_serial_shift.sv
// sac_serial_shift: serial-clock side of the readout shifter
// assumes word and tag are held still whenever the serial clock runs
`timescale 1ns/10ps
module sac_serial_shift
    import sac_pkg::*;
(
    // link clock and reset
    input wire logic serialClock,
    input wire logic rst_b,
    // word from the conversion domain, quasi-static
    input wire sac_code_t word,
    input wire logic wordTag,
    // link side
    output logic serialResultOut,
    output logic readDoneToggle
);

    logic rstMeta_q;
    logic rstSync_q;
    logic seenTag_q;
    logic [IDX_W:0] remain_q;

    // reset release retimed into the link domain
    always_ff @(posedge serialClock)
    begin
        rstMeta_q <= rst_b;
        rstSync_q <= rstMeta_q;
    end

    // launch on rising edge, host samples on falling edge; no divider here, the host owns the rate
    always_ff @(posedge serialClock)
    begin
        if (!rstSync_q)
        begin
            seenTag_q <= 1'b0;
            remain_q <= '0;
            serialResultOut <= 1'b0;
            readDoneToggle <= 1'b0;
        end
        else if (wordTag != seenTag_q)
        begin
            // fresh word: msb goes out on the first edge
            seenTag_q <= wordTag;
            serialResultOut <= word[RES_BITS-1];
            remain_q <= (IDX_W + 1)'(RES_BITS - 1);
        end
        else if (remain_q != '0)
        begin
            serialResultOut <= word[remain_q[IDX_W-1:0] - 1'b1];
            remain_q <= remain_q - 1'b1;
            if (remain_q == (IDX_W + 1)'(1))
            begin
                readDoneToggle <= !readDoneToggle;
            end
        end
        else
        begin
            serialResultOut <= 1'b0;
        end
    end

endmodule : sac_serial_shift

// File: design/sac_conversion_top.sv
// sac_conversion_top: conversion sequencing, self-calibration and readout of a sar converter
// assumes an analog comparator and trial dac outside, a host driving strobe, recalibrate and serial clock
`timescale 1ns/10ps

// Summary of operation
// - calibrate automatically after power-up
// - recalibrate command starts fresh calibration
// - after calibration enter standby, sampling connected
// - strobe rising edge starts a conversion
// - strobe low after done presents result
// - conversion timed by internal clock only
// - result appears in the very next readout
// - readout works up to 100 MHz
// - result width 16 bits
// - at most one conversion per microsecond
// - three wires: strobe, clock, data out
module sac_conversion_top
    import sac_pkg::*;
(
    // conversion clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // host pins
    input wire logic conversionStartStrobe,
    input wire logic serialClock,
    output logic serialResultOut,
    input wire logic recalibrateRequest,
    // analog core
    input wire logic comparatorAbove,
    output sac_code_t dacCode,
    output logic sampleConnect,
    output logic calShortInputs,
    // status
    output logic calibrating,
    output logic conversionActive
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    sac_state_e state_q;
    sac_state_e state_d;

    logic strobeMeta_q;
    logic strobeSync_q;
    logic strobePrev_q;
    logic strobeRise;

    logic recalMeta_q;
    logic recalSync_q;
    logic recalPrev_q;
    logic recalPending_q;

    logic [SPACE_W-1:0] sinceStart_q;
    logic spacingOk;
    logic startConv;

    logic [CAL_W-1:0] calCnt_q;
    logic calSettled;

    logic sarStart;
    logic sarBusy_q;
    logic sarDone_q;
    logic [IDX_W-1:0] bitIdx_q;

    sac_code_t offsetTrim_q;
    logic trimValid_q;
    logic signed [RES_BITS+1:0] corrSum;
    sac_code_t corrCode;
    sac_result_s result_q;

    logic fifoInValid;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    sac_result_s fifoOut;

    sac_code_t presentWord_q;
    logic presentTag_q;
    logic presentLoaded_q;

    logic readDoneToggle;
    logic doneMeta_q;
    logic doneSync_q;
    logic donePrev_q;
    logic readDone;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            strobeMeta_q <= 1'b0;
            strobeSync_q <= 1'b0;
            strobePrev_q <= 1'b0;
        end
        else
        begin
            strobeMeta_q <= conversionStartStrobe;
            strobeSync_q <= strobeMeta_q;
            strobePrev_q <= strobeSync_q;
        end
    end

    assign strobeRise = strobeSync_q && !strobePrev_q;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            recalMeta_q <= 1'b0;
            recalSync_q <= 1'b0;
            recalPrev_q <= 1'b0;
        end
        else
        begin
            recalMeta_q <= recalibrateRequest;
            recalSync_q <= recalMeta_q;
            recalPrev_q <= recalSync_q;
        end
    end

    // a request arriving as calibration begins is kept, set wins over clear
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            recalPending_q <= 1'b0;
        end
        else if (recalSync_q && !recalPrev_q)
        begin
            recalPending_q <= 1'b1;
        end
        else if (state_q == ST_STANDBY && state_d == ST_CAL)
        begin
            recalPending_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // start spacing
    // ----------------------------------------------------------------
    // saturating count of cycles since the last accepted start
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            sinceStart_q <= SPACE_W'(SAMPLE_PERIOD_CYC - 1);
        end
        else if (startConv)
        begin
            sinceStart_q <= '0;
        end
        else if (!spacingOk)
        begin
            sinceStart_q <= sinceStart_q + 1'b1;
        end
    end

    // too-early strobes are dropped rather than queued
    assign spacingOk = (sinceStart_q == SPACE_W'(SAMPLE_PERIOD_CYC - 1));
    assign startConv = (state_q == ST_STANDBY) && !recalPending_q && strobeRise && spacingOk;

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_CAL:
            begin
                if (sarDone_q)
                begin
                    state_d = ST_STANDBY;
                end
            end
            ST_STANDBY:
            begin
                // a pending recalibration is served before the next conversion
                if (recalPending_q)
                begin
                    state_d = ST_CAL;
                end
                else if (startConv)
                begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                // strobe edges here are ignored, host keeps it high
                if (sarDone_q)
                begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (!strobeSync_q)
                begin
                    state_d = ST_PUSH;
                end
            end
            ST_PUSH:
            begin
                // stalls here while the buffer is full
                if (fifoInReady)
                begin
                    state_d = ST_STANDBY;
                end
            end
            default:
            begin
                state_d = ST_CAL;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state_q <= ST_CAL;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // self-calibration settle
    // ----------------------------------------------------------------
    // inputs shorted and left to settle before the offset is measured
    always_ff @(posedge clock)
    begin
        if (!rst_b || state_q != ST_CAL)
        begin
            calCnt_q <= '0;
        end
        else if (!calSettled)
        begin
            calCnt_q <= calCnt_q + 1'b1;
        end
    end

    assign calSettled = (calCnt_q == CAL_W'(CAL_SETTLE_CYC));
    assign sarStart = ((state_q == ST_CAL) && calSettled && !sarBusy_q && !sarDone_q && calCnt_q != '0)
        || startConv;

    // ----------------------------------------------------------------
    // successive approximation
    // ----------------------------------------------------------------
    // one bit per conversion clock, no dependence on the serial clock
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            sarBusy_q <= 1'b0;
            sarDone_q <= 1'b0;
            bitIdx_q <= '0;
            dacCode <= MIDSCALE;
        end
        else
        begin
            sarDone_q <= 1'b0;
            if (sarStart)
            begin
                sarBusy_q <= 1'b1;
                bitIdx_q <= IDX_W'(RES_BITS - 1);
                dacCode <= MIDSCALE;
            end
            else if (sarBusy_q)
            begin
                dacCode[bitIdx_q] <= comparatorAbove;
                if (bitIdx_q != '0)
                begin
                    dacCode[bitIdx_q - 1'b1] <= 1'b1;
                    bitIdx_q <= bitIdx_q - 1'b1;
                end
                else
                begin
                    sarBusy_q <= 1'b0;
                    sarDone_q <= 1'b1;
                end
            end
        end
    end

    // offset only; gain and linearity trims live in the analog array
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            offsetTrim_q <= TRIM_RESET;
            trimValid_q <= 1'b0;
        end
        else if (state_q == ST_CAL && sarDone_q)
        begin
            offsetTrim_q <= dacCode;
            trimValid_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // offset correction
    // ----------------------------------------------------------------
    assign corrSum = $signed({2'b00, dacCode}) - $signed({2'b00, offsetTrim_q}) + $signed({2'b00, MIDSCALE});

    // clamp at zero and CODE_MAX so out-of-range sums saturate instead of wrapping
    always_comb
    begin
        if (corrSum < 0)
        begin
            corrCode = '0;
        end
        else if (corrSum > $signed({2'b00, CODE_MAX}))
        begin
            corrCode = CODE_MAX;
        end
        else
        begin
            corrCode = corrSum[RES_BITS-1:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            result_q <= '0;
        end
        else if (state_q == ST_CONVERT && sarDone_q)
        begin
            result_q.code <= corrCode;
            result_q.trimmed <= trimValid_q;
        end
    end

    // ----------------------------------------------------------------
    // result buffer
    // ----------------------------------------------------------------
    assign fifoInValid = (state_q == ST_PUSH);

    sac_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(result_q),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOut)
    );

    // drain only while nothing unread is on the shifter
    assign fifoOutReady = !presentLoaded_q && (state_q == ST_STANDBY || state_q == ST_PUSH);

    // ----------------------------------------------------------------
    // presented word
    // ----------------------------------------------------------------
    // word changes only outside reading windows, so the link side sees it still
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            presentWord_q <= '0;
            presentTag_q <= 1'b0;
        end
        else if (fifoOutValid && fifoOutReady)
        begin
            presentWord_q <= fifoOut.code;
            presentTag_q <= !presentTag_q;
        end
    end

    // a fresh start drops an unread word so no stale sample lingers
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            presentLoaded_q <= 1'b0;
        end
        else if (fifoOutValid && fifoOutReady)
        begin
            presentLoaded_q <= 1'b1;
        end
        else if (readDone || startConv)
        begin
            presentLoaded_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // link domain
    // ----------------------------------------------------------------
    sac_serial_shift u_shift (
        .serialClock(serialClock),
        .rst_b(rst_b),
        .word(presentWord_q),
        .wordTag(presentTag_q),
        .serialResultOut(serialResultOut),
        .readDoneToggle(readDoneToggle)
    );

    // toggle back across; the edge detect compares the second and third stages, never the first
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            doneMeta_q <= 1'b0;
            doneSync_q <= 1'b0;
            donePrev_q <= 1'b0;
        end
        else
        begin
            doneMeta_q <= readDoneToggle;
            doneSync_q <= doneMeta_q;
            donePrev_q <= doneSync_q;
        end
    end

    assign readDone = doneSync_q != donePrev_q;

    // ----------------------------------------------------------------
    // registered status and analog controls
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            sampleConnect <= 1'b0;
            calShortInputs <= 1'b0;
            calibrating <= 1'b0;
            conversionActive <= 1'b0;
        end
        else
        begin
            sampleConnect <= (state_d == ST_STANDBY);
            calShortInputs <= (state_d == ST_CAL);
            calibrating <= (state_d == ST_CAL);
            conversionActive <= (state_d == ST_CONVERT);
        end
    end

endmodule : sac_conversion_top

// File: test/sac_conversion_chk.sv
// sac_conversion_chk: port-level assertions on the conversion top
// assumes the host keeps strobe high past each conversion and clocks data only in standby
`timescale 1ns/10ps
module sac_conversion_chk
    import sac_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // host pins
    input wire logic conversionStartStrobe,
    input wire logic serialClock,
    input wire logic serialResultOut,
    input wire logic recalibrateRequest,
    // analog core
    input wire logic comparatorAbove,
    input wire sac_code_t dacCode,
    input wire logic sampleConnect,
    input wire logic calShortInputs,
    // status
    input wire logic calibrating,
    input wire logic conversionActive
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_CAL_AFTER_RESET: assert property ($rose(rst_b) |-> ##[1:2] calibrating)
        else $error("calibration did not start after reset");
    AST_CAL_SHORTS: assert property ($rose(calibrating) |-> calShortInputs)
        else $error("inputs not shorted at calibration start");
    AST_CAL_EXCLUSIVE: assert property (calibrating |-> !conversionActive)
        else $error("conversion during calibration");
    AST_RECAL_SERVED: assert property ($rose(recalibrateRequest) |-> ##[1:80] calibrating)
        else $error("recalibrate not served");
    AST_STANDBY_AFTER_CAL: assert property ($fell(calibrating) |-> ##[0:4] sampleConnect)
        else $error("no standby after calibration");
    AST_CAPS_OFF_IN_CONV: assert property (conversionActive |-> !sampleConnect)
        else $error("sampling caps connected during conversion");
    AST_START_CAUSE: assert property ($rose(conversionActive) |-> $past(conversionStartStrobe, 2))
        else $error("conversion started without strobe");
    // serial clock stands still here, so finishing proves the internal timing
    AST_CONV_LENGTH: assert property ($rose(conversionActive) |-> conversionActive[*8] ##[1:24] !conversionActive)
        else $error("conversion length out of bounds");

    // ----------------------------------------------------------------
    // covers
    // ----------------------------------------------------------------
    COV_CONV: cover property ($fell(conversionActive));
    COV_RECAL: cover property ($rose(recalibrateRequest) ##[1:80] calibrating);
    COV_READ: cover property (sampleConnect && serialClock);
endmodule : sac_conversion_chk

bind sac_conversion_top sac_conversion_chk u_sac_conversion_chk (.clock(clock), .rst_b(rst_b),
    .conversionStartStrobe(conversionStartStrobe), .serialClock(serialClock),
    .serialResultOut(serialResultOut), .recalibrateRequest(recalibrateRequest),
    .comparatorAbove(comparatorAbove), .dacCode(dacCode), .sampleConnect(sampleConnect),
    .calShortInputs(calShortInputs), .calibrating(calibrating), .conversionActive(conversionActive));

// File: test/sac_host_model.sv
// sac_host_model: host master driving strobe, serial clock and recalibrate pin
// assumes the conversion clock paces strobe and recalibrate; serial clock runs in frames and in bare bursts
`timescale 1ns/10ps
module sac_host_model
    import sac_pkg::*;
(
    // pacing clock
    input wire logic clock,
    // host pins
    output logic conversionStartStrobe,
    output logic serialClock,
    output logic recalibrateRequest,
    input wire logic serialResultOut
);
    localparam int SCLK_HALF_NS = 24;
    localparam int HOLD_CYC = 28;
    localparam int GAP_CYC = 10;

    initial
    begin
        conversionStartStrobe = 1'b0;
        serialClock = 1'b0;
        recalibrateRequest = 1'b0;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic burst(input int n);
        repeat (n)
        begin
            #SCLK_HALF_NS serialClock = 1'b1;
            #SCLK_HALF_NS serialClock = 1'b0;
        end
    endtask : burst

    task automatic setRecal(input logic level);
        @(posedge clock);
        #2 recalibrateRequest = level;
    endtask : setRecal

    // one strobe, then one 16-bit frame, sampled just before each falling edge
    task automatic convert(output sac_code_t word);
        int i;
        @(posedge clock);
        #2 conversionStartStrobe = 1'b1;
        repeat (HOLD_CYC) @(posedge clock);
        #2 conversionStartStrobe = 1'b0;
        repeat (GAP_CYC) @(posedge clock);
        word = '0;
        for (i = 0; i < RES_BITS; i++)
        begin
            #SCLK_HALF_NS serialClock = 1'b1;
            #SCLK_HALF_NS word = {word[RES_BITS-2:0], serialResultOut};
            serialClock = 1'b0;
        end
        repeat (GAP_CYC) @(posedge clock);
    endtask : convert
endmodule : sac_host_model

// File: test/sac_conversion_top_tb.sv
// sac_conversion_top_tb: self-checking bench with a behavioural comparator and host model
// assumes the comparator sees midscale plus an offset while inputs are shorted
`timescale 1ns/10ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module sac_conversion_top_tb
    import sac_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic conversionStartStrobe;
    logic serialClock;
    logic recalibrateRequest;
    logic serialResultOut;
    logic comparatorAbove;
    logic sampleConnect;
    logic calShortInputs;
    logic calibrating;
    logic conversionActive;
    sac_code_t dacCode;
    sac_code_t analogIn = 16'h0000;
    sac_code_t inputOffset = 16'h0010;
    int errCount = 0;
    int samplesChecked = 0;

    always #20 clock = ~clock;
    assign comparatorAbove = ((calShortInputs ? MIDSCALE + inputOffset : analogIn) >= dacCode);

    sac_conversion_top u_sac_conversion_top (.clock(clock), .rst_b(rst_b),
        .conversionStartStrobe(conversionStartStrobe), .serialClock(serialClock),
        .serialResultOut(serialResultOut), .recalibrateRequest(recalibrateRequest),
        .comparatorAbove(comparatorAbove), .dacCode(dacCode), .sampleConnect(sampleConnect),
        .calShortInputs(calShortInputs), .calibrating(calibrating), .conversionActive(conversionActive));

    sac_host_model u_sac_host_model (.clock(clock), .conversionStartStrobe(conversionStartStrobe),
        .serialClock(serialClock), .recalibrateRequest(recalibrateRequest),
        .serialResultOut(serialResultOut));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // offset correction saturates at zero
    function automatic sac_code_t expCode(input sac_code_t v, input sac_code_t off);
        return (v < off) ? 16'h0000 : v - off;
    endfunction : expCode

    task automatic completeRun();
        $display("mismatches %0d comparisons %0d", errCount, samplesChecked);
        if (errCount == 0 && samplesChecked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : completeRun

    task automatic waitCal(input logic level);
        int n;
        for (n = 0; n < 300 && calibrating !== level; n++)
            @(posedge clock);
        if (calibrating !== level)
        begin
            errCount++;
            completeRun();
        end
    endtask : waitCal

    task automatic runOne(input sac_code_t v);
        sac_code_t got;
        #2 analogIn = v;
        u_sac_host_model.convert(got);
        `CHK(got, expCode(v, inputOffset))
        `CHK(sampleConnect, 1'b1)
        `CHK(dacCode, v)
    endtask : runOne

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        int k;
        void'($urandom(71932));
        fork
            repeat (8) @(posedge clock);
            u_sac_host_model.burst(4);
        join
        `CHK(conversionActive, 1'b0)
        #2 rst_b = 1'b1;
        repeat (2) @(posedge clock);
        #2;
        `CHK(calibrating, 1'b1)
        `CHK(calShortInputs, 1'b1)
        // link-side reset retimer only lets go two serial edges after release
        u_sac_host_model.burst(3);
        waitCal(1'b0);
        repeat (4) @(posedge clock);
        `CHK(sampleConnect, 1'b1)
        // corners first: zero, full scale, exactly the offset
        for (k = 0; k < 14; k++)
            runOne(k == 0 ? 16'h0000 : k == 1 ? 16'hffff : k == 2 ? inputOffset : 16'($urandom()));
        inputOffset = 16'h0123;
        u_sac_host_model.setRecal(1'b1);
        waitCal(1'b1);
        `CHK(calibrating, 1'b1)
        waitCal(1'b0);
        u_sac_host_model.setRecal(1'b0);
        repeat (4) @(posedge clock);
        runOne(16'h0100);
        runOne(16'h9000);
        completeRun();
    end

    initial
    begin
        repeat (100000) @(posedge clock);
        errCount++;
        completeRun();
    end
endmodule : sac_conversion_top_tb
